/* File: logic/sfr_ext_pkg.sv */
package sfr_ext_pkg;

  // Register bus geometry and byte offsets
  localparam int BUS_ADDR_W = 4;
  localparam int BUS_DATA_W = 32;
  localparam int BUS_BE_W = 4;
  localparam logic [BUS_ADDR_W-1:0] SYSCON_OFFSET = 4'h0;
  localparam logic [BUS_ADDR_W-1:0] PAGE_OFFSET = 4'h4;
  localparam logic [23:0] READ_PAD_ZERO = 24'h00_0000;

  // System control register layout
  localparam logic [7:0] SYSCON_RESET = 8'h04;
  localparam logic [7:0] SYSCON_READ_ONES = 8'h04;
  localparam logic [7:0] SYSCON_READ_ZEROS = 8'hEA;
  localparam int SYSCON_MAP_BIT = 0;
  localparam int SYSCON_ONE_BIT = 2;
  localparam int SYSCON_IMODE_BIT = 4;

  // Module page register layout
  localparam int PAGE_OP_LO = 6;
  localparam int PAGE_OP_W = 2;
  localparam int PAGE_SLOT_LO = 4;
  localparam int PAGE_SLOT_FIELD_W = 2;
  localparam int PAGE_RSVD_BIT = 3;
  localparam int PAGE_VALUE_LO = 0;
  localparam int PAGE_VALUE_FIELD_W = 3;
  localparam int DEFAULT_PAGE_W = 3;
  localparam int DEFAULT_SLOTS = 4;

  // Directly addressable function-register space
  localparam int SFR_SPACE = 256;
  localparam int SFR_ADDR_W = $clog2(SFR_SPACE);

  typedef enum logic [1:0]
  {
    OP_MANUAL_A = 2'h0,
    OP_MANUAL_B = 2'h1,
    OP_SAVE = 2'h2,
    OP_RESTORE = 2'h3
  } page_op_t;

  typedef enum logic
  {
    BUS_IDLE = 1'h0,
    BUS_ACK = 1'h1
  } bus_state_t;

endpackage : sfr_ext_pkg

/* File: logic/sfr_area_steer.sv */
`timescale 1ns/1ps
module sfr_area_steer
  import sfr_ext_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Core side
  input wire logic req_in,
  input wire logic [SFR_ADDR_W-1:0] addr_in,
  input wire logic map_in,
  // Area side
  output logic std_req_out,
  output logic map_req_out,
  output logic [SFR_ADDR_W-1:0] addr_out
);

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      std_req_out <= 1'b0;
      map_req_out <= 1'b0;
    end
    else
    begin
      std_req_out <= req_in & ~map_in;
      map_req_out <= req_in & map_in;
    end
  end

  // Same eight address bits reach whichever area is chosen
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      addr_out <= '0;
    else if (req_in)
      addr_out <= addr_in;
  end

endmodule : sfr_area_steer

/* File: logic/page_store.sv */
`timescale 1ns/1ps
module page_store
  import sfr_ext_pkg::*;
#(
  parameter int PAGE_W = DEFAULT_PAGE_W,
  parameter int SLOTS = DEFAULT_SLOTS,
  parameter int SLOT_W = (SLOTS > 1) ? $clog2(SLOTS) : 1
)
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Write command
  input wire logic wr_in,
  input wire page_op_t op_in,
  input wire logic [SLOT_W-1:0] slot_in,
  input wire logic [PAGE_W-1:0] page_in,
  // Current page
  output logic [PAGE_W-1:0] page_out,
  output logic [SLOT_W-1:0] slot_out
);

  logic [PAGE_W-1:0] saved_page_slot [SLOTS];
  logic slot_ok;

  // Slot numbers past the last slot neither save nor restore
  assign slot_ok = (32'(slot_in) < SLOTS);

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      page_out <= '0;
      slot_out <= '0;
    end
    else if (wr_in)
    begin
      slot_out <= slot_in;
      case (op_in)
        OP_MANUAL_A, OP_MANUAL_B: page_out <= page_in;
        OP_SAVE: page_out <= page_in;
        OP_RESTORE:
          if (slot_ok)
            page_out <= saved_page_slot[slot_in];
        default: page_out <= page_out;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < SLOTS; g++)
    begin : g_slot
      always_ff @(posedge sys_clk_in or posedge sys_rst_in)
      begin
        if (sys_rst_in)
          saved_page_slot[g] <= '0;
        else if (wr_in && op_in == OP_SAVE && 32'(slot_in) == g)
          saved_page_slot[g] <= page_out;
      end
    end
  endgenerate

endmodule : page_store

/* File: logic/sfr_map_and_page_extension.sv */
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module sfr_map_and_page_extension
  import sfr_ext_pkg::*;
#(
  parameter int PAGE_W = DEFAULT_PAGE_W,
  parameter int SLOTS = DEFAULT_SLOTS,
  parameter int SLOT_W = (SLOTS > 1) ? $clog2(SLOTS) : 1
)
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Avalon-MM register slave
  input wire logic [sfr_ext_pkg::BUS_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [sfr_ext_pkg::BUS_DATA_W-1:0] avs_writedata_in,
  input wire logic [sfr_ext_pkg::BUS_BE_W-1:0] avs_byteenable_in,
  output logic [sfr_ext_pkg::BUS_DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Core function-register access
  input wire logic core_req_in,
  input wire logic [sfr_ext_pkg::SFR_ADDR_W-1:0] core_addr_in,
  // Area steering
  output logic std_req_out,
  output logic map_req_out,
  output logic [sfr_ext_pkg::SFR_ADDR_W-1:0] sfr_addr_out,
  // Control state
  output logic map_select_out,
  output logic interrupt_mode_out,
  output logic [PAGE_W-1:0] page_out
);

  import sfr_ext_pkg::*;

  bus_state_t bus_state_reg;
  bus_state_t bus_state_next;
  logic bus_req;
  logic sel_syscon;
  logic sel_page;
  logic wr_take;
  logic rd_take;
  logic sfr_map_select_reg;
  logic imode_reg;
  logic [7:0] syscon_view;
  logic [7:0] page_view;
  logic [7:0] read_byte;
  logic [SLOT_W-1:0] slot_cur;
  logic page_wr;
  page_op_t page_operation;
  logic [SLOT_W-1:0] storage_slot_number;
  logic [PAGE_W-1:0] page_value_in;

  // Bus slave: one wait state on every access
  assign bus_req = avs_read_in | avs_write_in;
  assign sel_syscon = (avs_address_in == SYSCON_OFFSET);
  assign sel_page = (avs_address_in == PAGE_OFFSET);
  assign avs_waitrequest_out = bus_req & (bus_state_reg != BUS_ACK);
  assign wr_take = avs_write_in & (bus_state_reg == BUS_ACK);
  assign rd_take = avs_read_in & (bus_state_reg == BUS_ACK);

  always_comb
  begin
    bus_state_next = bus_state_reg;
    case (bus_state_reg)
      BUS_IDLE:
        if (bus_req)
          bus_state_next = BUS_ACK;
      BUS_ACK: bus_state_next = BUS_IDLE;
      default: bus_state_next = BUS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      bus_state_reg <= BUS_IDLE;
    else
      bus_state_reg <= bus_state_next;
  end

  // System control register; only the map and mode bits are stored
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sfr_map_select_reg <= SYSCON_RESET[SYSCON_MAP_BIT];
      imode_reg <= SYSCON_RESET[SYSCON_IMODE_BIT];
    end
    else if (wr_take && sel_syscon && avs_byteenable_in[0])
    begin
      sfr_map_select_reg <= avs_writedata_in[SYSCON_MAP_BIT];
      imode_reg <= avs_writedata_in[SYSCON_IMODE_BIT];
    end
  end

  // Fixed bits come from a constant, so writes cannot disturb them
  always_comb
  begin
    syscon_view = SYSCON_READ_ONES;
    syscon_view[SYSCON_MAP_BIT] = sfr_map_select_reg;
    syscon_view[SYSCON_IMODE_BIT] = imode_reg;
  end

  // Page register command fields
  assign page_wr = wr_take & sel_page & avs_byteenable_in[0];
  assign page_operation =
    page_op_t'(avs_writedata_in[PAGE_OP_LO +: PAGE_OP_W]);
  assign storage_slot_number = avs_writedata_in[PAGE_SLOT_LO +: SLOT_W];
  assign page_value_in = avs_writedata_in[PAGE_VALUE_LO +: PAGE_W];

  page_store #(
    .PAGE_W(PAGE_W),
    .SLOTS(SLOTS),
    .SLOT_W(SLOT_W)
  ) u_pages (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_in(page_wr),
    .op_in(page_operation),
    .slot_in(storage_slot_number),
    .page_in(page_value_in),
    .page_out(page_out),
    .slot_out(slot_cur)
  );

  // Operation bits are write-only and read back as zero
  always_comb
  begin
    page_view = 8'h00;
    page_view[PAGE_VALUE_LO +: PAGE_W] = page_out;
    page_view[PAGE_SLOT_LO +: SLOT_W] = slot_cur;
    page_view[PAGE_RSVD_BIT] = 1'b0;
  end

  always_comb
  begin
    read_byte = 8'h00;
    if (sel_syscon)
      read_byte = syscon_view;
    else if (sel_page)
      read_byte = page_view;
  end

  // Read data is captured in the wait cycle and stands at the ack edge
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      avs_readdata_out <= '0;
    else if (avs_read_in && bus_state_reg == BUS_IDLE)
      avs_readdata_out <= {READ_PAD_ZERO, read_byte};
  end

  sfr_area_steer u_steer (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .req_in(core_req_in),
    .addr_in(core_addr_in),
    .map_in(sfr_map_select_reg),
    .std_req_out(std_req_out),
    .map_req_out(map_req_out),
    .addr_out(sfr_addr_out)
  );

  assign map_select_out = sfr_map_select_reg;
  assign interrupt_mode_out = imode_reg;

  // Checks
  sequence s_page_cmd(page_op_t op);
    page_wr && page_operation == op;
  endsequence

  sequence s_slot_cmd(page_op_t op);
    page_wr && page_operation == op && 32'(storage_slot_number) < SLOTS;
  endsequence

  sequence s_missing_slot_cmd(page_op_t op);
    page_wr && page_operation == op && 32'(storage_slot_number) >= SLOTS;
  endsequence

  sequence s_syscon_write;
    wr_take && sel_syscon && avs_byteenable_in[0];
  endsequence

  sequence s_syscon_read;
    rd_take && sel_syscon;
  endsequence

  sequence s_page_read;
    rd_take && sel_page;
  endsequence

  a_map_standard: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    core_req_in && !sfr_map_select_reg |=> std_req_out && !map_req_out)
    else $error("standard area not selected with map bit clear");

  a_map_alternate: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    core_req_in && sfr_map_select_reg |=> map_req_out && !std_req_out)
    else $error("mapped area not selected with map bit set");

  a_steer_idle: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    !core_req_in |=> !std_req_out && !map_req_out)
    else $error("area request without core request");

  a_syscon_reset: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    $past(sys_rst_in) |-> syscon_view == SYSCON_RESET && !map_select_out)
    else $error("system control not at reset value");

  a_syscon_one: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    s_syscon_read |=> avs_readdata_out[SYSCON_ONE_BIT] == 1'b1)
    else $error("system control bit 2 read as zero");

  a_syscon_zeros: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    s_syscon_read |=>
      (avs_readdata_out[7:0] & SYSCON_READ_ZEROS) == 8'h00)
    else $error("system control reserved bits read as one");

  a_syscon_update: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    wr_take && sel_syscon && avs_byteenable_in[0] |=>
      map_select_out == $past(avs_writedata_in[SYSCON_MAP_BIT]))
    else $error("map bit not taken from write");

  a_sfr_address: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    core_req_in |=> sfr_addr_out == $past(core_addr_in))
    else $error("function-register address not passed through");

  a_page_manual: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (s_page_cmd(OP_MANUAL_A) or s_page_cmd(OP_MANUAL_B)) |=>
      page_out == $past(page_value_in))
    else $error("manual page write not stored");

  a_page_save: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    s_slot_cmd(OP_SAVE) |=>
      page_out == $past(page_value_in) &&
      u_pages.saved_page_slot[$past(storage_slot_number)] ==
        $past(page_out))
    else $error("save operation lost the new or old page");

  a_page_restore: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    s_slot_cmd(OP_RESTORE) |=>
      page_out == $past(u_pages.saved_page_slot[storage_slot_number]))
    else $error("restore operation did not reload the page");

  a_page_reserved: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    s_page_read |=> avs_readdata_out[PAGE_RSVD_BIT] == 1'b0)
    else $error("page register bit 3 read as one");

  a_slot_range: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    s_missing_slot_cmd(OP_RESTORE) |=>
      $stable(page_out))
    else $error("restore from a missing slot changed the page");

  a_bus_answer: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    bus_req && bus_state_reg == BUS_IDLE |=> !avs_waitrequest_out)
    else $error("bus access not answered after one wait state");

  // Other bits must survive, or read-modify-write updates would be lost
  a_syscon_hold: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    !(wr_take && sel_syscon && avs_byteenable_in[0]) |=>
      $stable(map_select_out) && $stable(interrupt_mode_out))
    else $error("system control changed without a write");

  a_mode_update: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    s_syscon_write |=>
      interrupt_mode_out == $past(avs_writedata_in[SYSCON_IMODE_BIT]))
    else $error("mode bit not taken from write");

  a_page_hold: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    !page_wr |=> $stable(page_out))
    else $error("page changed without a page write");

  a_page_op_zero: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    s_page_read |=>
      avs_readdata_out[PAGE_OP_LO +: PAGE_OP_W] == '0)
    else $error("page operation field read back nonzero");

  a_page_readback: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    s_page_read |=>
      avs_readdata_out[PAGE_VALUE_LO +: PAGE_W] == $past(page_out))
    else $error("page read back differs from current page");

  a_syscon_readback: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    s_syscon_read |=>
      avs_readdata_out[SYSCON_MAP_BIT] == $past(map_select_out))
    else $error("map bit read back differs from register");

  a_read_pad: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    rd_take |=>
      avs_readdata_out[BUS_DATA_W-1:$bits(read_byte)] == READ_PAD_ZERO)
    else $error("upper read data bits not zero");

  a_unmapped_read: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    rd_take && !sel_syscon && !sel_page |=> avs_readdata_out == '0)
    else $error("unmapped offset read back nonzero");

  a_readdata_hold: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    !(avs_read_in && bus_state_reg == BUS_IDLE) |=>
      $stable(avs_readdata_out))
    else $error("read data changed outside a read capture");

  // A restore or a save elsewhere must leave every other slot alone
  genvar k;
  generate
    for (k = 0; k < SLOTS; k++)
    begin : g_slot_check
      a_slot_keep: assert property (
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        !(page_wr && page_operation == OP_SAVE &&
          32'(storage_slot_number) == k) |=>
          $stable(u_pages.saved_page_slot[k]))
        else $error("storage slot changed without a save into it");
    end
  endgenerate

endmodule : sfr_map_and_page_extension

/* File: dv/tb_sfr_map_and_page_extension.sv */
`timescale 1ns/1ps
module tb_sfr_map_and_page_extension;
  import sfr_ext_pkg::*;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [3:0] avs_address_in = 4'h0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0000_0000;
  logic [3:0] avs_byteenable_in = 4'hF;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic core_req_in = 1'b0;
  logic [7:0] core_addr_in = 8'h00;
  logic std_req_out;
  logic map_req_out;
  logic [7:0] sfr_addr_out;
  logic map_select_out;
  logic interrupt_mode_out;
  logic [2:0] page_out;
  int miscompares = 0;
  int check_count = 0;
  logic [31:0] rd;

  always #2 sys_clk_in = ~sys_clk_in;

  sfr_map_and_page_extension dut (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .core_req_in(core_req_in),
    .core_addr_in(core_addr_in),
    .std_req_out(std_req_out),
    .map_req_out(map_req_out),
    .sfr_addr_out(sfr_addr_out),
    .map_select_out(map_select_out),
    .interrupt_mode_out(interrupt_mode_out),
    .page_out(page_out)
  );

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic bus_write(input logic [3:0] a, input logic [7:0] d,
    input logic [3:0] be);
    @(posedge sys_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= {24'h00_0000, d};
    avs_byteenable_in <= be;
    avs_write_in <= 1'b1;
    do @(posedge sys_clk_in); while (avs_waitrequest_out !== 1'b0);
    avs_write_in <= 1'b0;
    #1;
  endtask : bus_write

  task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk_in);
    avs_address_in <= a;
    avs_read_in <= 1'b1;
    do @(posedge sys_clk_in); while (avs_waitrequest_out !== 1'b0);
    d = avs_readdata_out;
    avs_read_in <= 1'b0;
  endtask : bus_read

  task automatic test_reset();
    bus_read(SYSCON_OFFSET, rd);
    check("syscon reset", rd, 32'h0000_0004);
    check("map reset", 32'(map_select_out), 32'h0000_0000);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_syscon();
    bus_write(SYSCON_OFFSET, 8'hFF, 4'h1);
    check("mode set", 32'(interrupt_mode_out), 32'h0000_0001);
    bus_read(SYSCON_OFFSET, rd);
    check("syscon ones", rd, 32'h0000_0015);
    bus_write(SYSCON_OFFSET, 8'h00, 4'h1);
    check("mode clear", 32'(interrupt_mode_out), 32'h0000_0000);
    bus_read(SYSCON_OFFSET, rd);
    check("syscon zeros", rd, 32'h0000_0004);
    // Disabled lane and unmapped offset must both leave the register alone
    bus_write(SYSCON_OFFSET, 8'h11, 4'h0);
    bus_write(4'h8, 8'h11, 4'h1);
    bus_read(SYSCON_OFFSET, rd);
    check("syscon kept", rd, 32'h0000_0004);
    bus_read(4'h8, rd);
    check("unmapped", rd, 32'h0000_0000);
    $display("test_syscon done");
  endtask : test_syscon

  task automatic test_steer();
    logic [7:0] a;
    for (int m = 0; m < 2; m++)
    begin
      bus_read(SYSCON_OFFSET, rd);
      bus_write(SYSCON_OFFSET, (m != 0) ? (rd[7:0] | 8'h01) :
        (rd[7:0] & 8'hFE), 4'h1);
      check("map bit", 32'(map_select_out), 32'(m));
      // Both ends of the 256-location space
      for (int i = 0; i < 2; i++)
      begin
        a = (i != 0) ? 8'hFF : 8'h00;
        @(posedge sys_clk_in);
        core_req_in <= 1'b1;
        core_addr_in <= a;
        @(posedge sys_clk_in);
        core_req_in <= 1'b0;
        #1;
        check("std req", 32'(std_req_out), 32'(m == 0));
        check("map req", 32'(map_req_out), 32'(m == 1));
        check("sfr addr", 32'(sfr_addr_out), 32'(a));
      end
    end
    $display("test_steer done");
  endtask : test_steer

  task automatic test_page();
    // Direct, save, restore; the sixth and seventh hit slots never saved
    logic [7:0] wd [8] = '{8'h35, 8'h62, 8'h96, 8'hA3,
      8'hE0, 8'hF0, 8'hC7, 8'hDF};
    logic [2:0] pg [8] = '{3'h5, 3'h2, 3'h6, 3'h3,
      3'h6, 3'h0, 3'h0, 3'h2};
    for (int i = 0; i < 8; i++)
    begin
      bus_write(PAGE_OFFSET, wd[i], 4'h1);
      check("page", 32'(page_out), 32'(pg[i]));
    end
    bus_read(PAGE_OFFSET, rd);
    check("page read", rd, 32'h0000_0012);
    bus_write(PAGE_OFFSET, 8'h07, 4'h0);
    check("page be", 32'(page_out), 32'h0000_0002);
    $display("test_page done");
  endtask : test_page

  task automatic test_rereset();
    @(posedge sys_clk_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    bus_read(SYSCON_OFFSET, rd);
    check("syscon rereset", rd, 32'h0000_0004);
    check("map rereset", 32'(map_select_out), 32'h0000_0000);
    check("page rereset", 32'(page_out), 32'h0000_0000);
    $display("test_rereset done");
  endtask : test_rereset

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (20) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    test_reset();
    test_syscon();
    test_steer();
    test_page();
    test_rereset();
    end_of_test();
  end

  // The tests need about a hundred cycles; a hundred times that means a hang
  initial
  begin
    repeat (10000) @(posedge sys_clk_in);
    miscompares++;
    end_of_test();
  end
endmodule : tb_sfr_map_and_page_extension
